//--- rtl/tmr0_core.sv
module tmr0_core
  import tmr0_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input tmr0_bus_req_t BUS_REQ_I,
  output logic [7:0] BUS_RDATA_O,
  input wire logic GLOBAL_IRQ_EN_I,
  input wire logic [2:0] IRQ_ACK_I,
  input wire logic EXT_COUNT_PIN_I,
  input wire logic ASYNC_MODE_I,
  input wire logic ASYNC_RST_DONE_I,
  output logic ASYNC_PRESC_RST_O,
  output logic SHARED_PRESC_RST_O,
  output logic IRQ_OVF_O,
  output logic IRQ_CMP_A_O,
  output logic IRQ_CMP_B_O,
  output logic WAVE_OUT_A_O,
  output logic WAVE_OUT_A_EN_O,
  output logic WAVE_OUT_B_O,
  output logic WAVE_OUT_B_EN_O
);

  // Effective data-space address of an access
  function automatic logic [7:0] eff_addr(input tmr0_bus_req_t r);
    if (r.io_sel)
      eff_addr = (r.addr <= TMR0_IO_LAST) ? r.addr + TMR0_IO_SHIFT : 8'h00;
    else
      eff_addr = r.addr;
  endfunction

  // Register contents
  logic [1:0] out_mode_a_q;
  logic [1:0] out_mode_b_q;
  logic [2:0] waveform_mode_sel_q;
  logic [2:0] clock_select_field_q;
  logic [7:0] counter_value_q;
  logic [7:0] compare_a_value_q;
  logic [7:0] compare_b_value_q;
  // Working copies that the comparators use
  logic [7:0] cmp_a_live_q;
  logic [7:0] cmp_b_live_q;
  logic cmp_a_irq_en_q;
  logic cmp_b_irq_en_q;
  logic overflow_irq_en_q;
  logic cmp_a_flag_q;
  logic cmp_b_flag_q;
  logic overflow_flag_q;
  logic sync_hold_mode_q;
  logic async_prescaler_reset_q;
  logic shared_prescaler_reset_q;
  // Compare suppression after a software counter write
  logic block_q;
  // Phase correct direction, high while counting up
  logic count_up_q;

  // Address decode
  wire [7:0] ea = eff_addr(BUS_REQ_I);
  wire hit_sync = ea == TMR0_OFF_SYNC;
  wire hit_ctrl_a = ea == TMR0_OFF_CTRL_A;
  wire hit_ctrl_b = ea == TMR0_OFF_CTRL_B;
  wire hit_count = ea == TMR0_OFF_COUNT;
  wire hit_cmp_a = ea == TMR0_OFF_CMP_A;
  wire hit_cmp_b = ea == TMR0_OFF_CMP_B;
  wire hit_mask = ea == TMR0_OFF_MASK;
  wire hit_flags = ea == TMR0_OFF_FLAGS;
  wire we = BUS_REQ_I.we;
  wire [7:0] wd = BUS_REQ_I.wdata;

  // Waveform family decode
  wire is_phase = waveform_mode_sel_q[1:0] == 2'h1;
  wire is_fast = waveform_mode_sel_q[1:0] == 2'h3;
  wire is_ctc = waveform_mode_sel_q == 3'h2;
  wire is_pwm = is_phase | is_fast;
  wire top_is_cmp = is_ctc | (is_pwm & waveform_mode_sel_q[2]);
  wire [7:0] top = top_is_cmp ? cmp_a_live_q : TMR0_MAX;
  tmr0_wkind_t kind;

  assign kind = is_fast ? TMR0_WK_FAST : (is_phase ? TMR0_WK_PHASE :
                TMR0_WK_NONPWM);

  // Timer clock from the prescaler or the count pin
  logic tick;
  tmr0_prescaler u_presc (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .presc_clr_i(shared_prescaler_reset_q),
    .sel_i(clock_select_field_q),
    .ext_pin_i(EXT_COUNT_PIN_I),
    .tick_o(tick)
  );

  // Counter events
  wire cpu_cnt_wr = we & hit_count;
  wire at_top = counter_value_q == top;
  wire at_bottom = counter_value_q == TMR0_BOTTOM;
  wire match_a = tick & ~block_q &
                 (counter_value_q == cmp_a_live_q);
  wire match_b = tick & ~block_q &
                 (counter_value_q == cmp_b_live_q);
  // Overflow point depends on the family
  wire ovf_evt = tick & (is_phase ? (at_bottom & ~count_up_q) :
                 ((is_fast & waveform_mode_sel_q[2]) ? at_top :
                 (counter_value_q == TMR0_MAX)));
  // Fast PWM restarts at bottom on the tick after top
  wire fast_wrap = tick & is_fast & at_top;
  // Force strobes act only outside PWM and touch only the outputs
  wire force_a = we & hit_ctrl_b & wd[TMR0_B_FORCE_A] & ~is_pwm;
  wire force_b = we & hit_ctrl_b & wd[TMR0_B_FORCE_B] & ~is_pwm;
  // Compare values reload at once outside PWM, or at top in PWM
  wire reload = ~is_pwm | (tick & at_top);

  // Next counter value
  logic [7:0] cnt_d;
  logic up_d;
  always_comb
  begin
    cnt_d = counter_value_q;
    up_d = count_up_q;
    if (cpu_cnt_wr)
      cnt_d = wd;
    else if (tick && is_phase)
    begin
      // Turn round at top and at bottom
      if (count_up_q && at_top)
      begin
        up_d = 1'b0;
        cnt_d = counter_value_q - 8'h01;
      end
      else if (!count_up_q && at_bottom)
      begin
        up_d = 1'b1;
        cnt_d = counter_value_q + 8'h01;
      end
      else
        cnt_d = count_up_q ? counter_value_q + 8'h01 :
                counter_value_q - 8'h01;
    end
    else if (tick)
    begin
      // Only a real match clears in CTC, never a force
      if (top_is_cmp && at_top)
        cnt_d = TMR0_BOTTOM;
      else
        cnt_d = counter_value_q + 8'h01;
    end
    if (!is_phase)
      up_d = 1'b1;
  end

  // Counter, direction and write block
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      counter_value_q <= TMR0_RST_VAL;
      count_up_q <= 1'b1;
      block_q <= 1'b0;
    end
    else
    begin
      counter_value_q <= cnt_d;
      count_up_q <= up_d;
      // Held until one timer tick has passed without a match
      block_q <= cpu_cnt_wr | (block_q & ~tick);
    end
  end

  // Control and compare registers
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      out_mode_a_q <= 2'h0;
      out_mode_b_q <= 2'h0;
      waveform_mode_sel_q <= 3'h0;
      clock_select_field_q <= 3'h0;
      compare_a_value_q <= TMR0_RST_VAL;
      compare_b_value_q <= TMR0_RST_VAL;
      cmp_a_live_q <= TMR0_RST_VAL;
      cmp_b_live_q <= TMR0_RST_VAL;
      cmp_a_irq_en_q <= 1'b0;
      cmp_b_irq_en_q <= 1'b0;
      overflow_irq_en_q <= 1'b0;
    end
    else
    begin
      if (we && hit_ctrl_a)
      begin
        out_mode_a_q <= wd[7:6];
        out_mode_b_q <= wd[5:4];
        waveform_mode_sel_q[1:0] <= wd[1:0];
      end
      if (we && hit_ctrl_b)
      begin
        waveform_mode_sel_q[2] <= wd[TMR0_B_WGM2];
        clock_select_field_q <= wd[2:0];
      end
      if (we && hit_cmp_a)
        compare_a_value_q <= wd;
      if (we && hit_cmp_b)
        compare_b_value_q <= wd;
      // Buffered copies avoid glitches mid-period in PWM
      if (reload)
      begin
        cmp_a_live_q <= (we && hit_cmp_a) ? wd : compare_a_value_q;
        cmp_b_live_q <= (we && hit_cmp_b) ? wd : compare_b_value_q;
      end
      if (we && hit_mask)
      begin
        cmp_b_irq_en_q <= wd[TMR0_B_CMP_B];
        cmp_a_irq_en_q <= wd[TMR0_B_CMP_A];
        overflow_irq_en_q <= wd[TMR0_B_OVF];
      end
    end
  end

  // Event flags: a set in the same cycle beats any clear
  wire clr_wr = we & hit_flags;
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      cmp_a_flag_q <= 1'b0;
      cmp_b_flag_q <= 1'b0;
      overflow_flag_q <= 1'b0;
    end
    else
    begin
      overflow_flag_q <= ovf_evt | (overflow_flag_q &
        ~(IRQ_ACK_I[TMR0_B_OVF] | (clr_wr & wd[TMR0_B_OVF])));
      cmp_a_flag_q <= match_a | (cmp_a_flag_q &
        ~(IRQ_ACK_I[TMR0_B_CMP_A] | (clr_wr & wd[TMR0_B_CMP_A])));
      cmp_b_flag_q <= match_b | (cmp_b_flag_q &
        ~(IRQ_ACK_I[TMR0_B_CMP_B] | (clr_wr & wd[TMR0_B_CMP_B])));
    end
  end

  // Synchronisation and prescaler reset bits
  wire sync_wr = we & hit_sync;
  wire hold_d = sync_wr ? wd[TMR0_B_SYNC_HOLD] : sync_hold_mode_q;
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      sync_hold_mode_q <= 1'b0;
      async_prescaler_reset_q <= 1'b0;
      shared_prescaler_reset_q <= 1'b0;
    end
    else
    begin
      sync_hold_mode_q <= hold_d;
      if (sync_wr)
      begin
        // Written values land; they persist only while hold is on, or for async in async mode until done
        async_prescaler_reset_q <= wd[TMR0_B_ASYNC_PSR];
        shared_prescaler_reset_q <= wd[TMR0_B_SHARED_PSR];
      end
      else if (!sync_hold_mode_q)
      begin
        // Out of hold shared drops at once; async drops with it outside async mode, else waits for done
        shared_prescaler_reset_q <= 1'b0;
        if (!ASYNC_MODE_I || ASYNC_RST_DONE_I)
          async_prescaler_reset_q <= 1'b0;
      end
    end
  end

  assign ASYNC_PRESC_RST_O = async_prescaler_reset_q;
  assign SHARED_PRESC_RST_O = shared_prescaler_reset_q;

  // Interrupt requests gated by the core's global enable
  assign IRQ_OVF_O = overflow_irq_en_q & GLOBAL_IRQ_EN_I &
                     overflow_flag_q;
  assign IRQ_CMP_A_O = cmp_a_irq_en_q & GLOBAL_IRQ_EN_I &
                       cmp_a_flag_q;
  assign IRQ_CMP_B_O = cmp_b_irq_en_q & GLOBAL_IRQ_EN_I &
                       cmp_b_flag_q;

  // Waveform outputs, one unit per channel
  tmr0_wave_unit u_wave_a (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .kind_i(kind),
    .out_mode_i(out_mode_a_q),
    .toggle_ok_i(waveform_mode_sel_q[2]),
    .match_i(match_a),
    .force_i(force_a),
    .bottom_i(fast_wrap),
    .count_up_i(count_up_q),
    .wave_o(WAVE_OUT_A_O)
  );

  // Channel B never toggles in PWM modes
  tmr0_wave_unit u_wave_b (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .kind_i(kind),
    .out_mode_i(out_mode_b_q),
    .toggle_ok_i(1'b0),
    .match_i(match_b),
    .force_i(force_b),
    .bottom_i(fast_wrap),
    .count_up_i(count_up_q),
    .wave_o(WAVE_OUT_B_O)
  );

  // Pin takes the waveform only when an output mode is chosen
  assign WAVE_OUT_A_EN_O = (out_mode_a_q != 2'h0) &&
    !(is_pwm && out_mode_a_q == 2'h1 && !waveform_mode_sel_q[2]);
  assign WAVE_OUT_B_EN_O = (out_mode_b_q != 2'h0) &&
    !(is_pwm && out_mode_b_q == 2'h1);

  // Read multiplexer; reserved bits and unmapped reads give zero
  always_comb
  begin
    BUS_RDATA_O = 8'h00;
    if (BUS_REQ_I.re)
    begin
      if (hit_sync)
        BUS_RDATA_O = {sync_hold_mode_q, 5'h00, async_prescaler_reset_q,
                       shared_prescaler_reset_q};
      else if (hit_ctrl_a)
        BUS_RDATA_O = {out_mode_a_q, out_mode_b_q, 2'h0,
                       waveform_mode_sel_q[1:0]};
      else if (hit_ctrl_b)
        BUS_RDATA_O = {2'h0, 2'h0, waveform_mode_sel_q[2],
                       clock_select_field_q};
      else if (hit_count)
        BUS_RDATA_O = counter_value_q;
      else if (hit_cmp_a)
        BUS_RDATA_O = compare_a_value_q;
      else if (hit_cmp_b)
        BUS_RDATA_O = compare_b_value_q;
      else if (hit_mask)
        BUS_RDATA_O = {5'h00, cmp_b_irq_en_q, cmp_a_irq_en_q,
                       overflow_irq_en_q};
      else if (hit_flags)
        BUS_RDATA_O = {5'h00, cmp_b_flag_q, cmp_a_flag_q,
                       overflow_flag_q};
    end
  end

endmodule

//--- rtl/tmr0_pkg.sv
package tmr0_pkg;

  // Register data-space offsets
  localparam logic [7:0] TMR0_OFF_SYNC = 8'h43;
  localparam logic [7:0] TMR0_OFF_CTRL_A = 8'h44;
  localparam logic [7:0] TMR0_OFF_CTRL_B = 8'h45;
  localparam logic [7:0] TMR0_OFF_COUNT = 8'h46;
  localparam logic [7:0] TMR0_OFF_CMP_A = 8'h47;
  localparam logic [7:0] TMR0_OFF_CMP_B = 8'h48;
  localparam logic [7:0] TMR0_OFF_MASK = 8'h6e;
  localparam logic [7:0] TMR0_OFF_FLAGS = 8'h35;
  // I/O instructions address the same registers this much lower
  localparam logic [7:0] TMR0_IO_SHIFT = 8'h20;
  localparam logic [7:0] TMR0_IO_LAST = 8'h3f;

  // Field positions
  localparam int TMR0_B_FORCE_A = 7;
  localparam int TMR0_B_FORCE_B = 6;
  localparam int TMR0_B_WGM2 = 3;
  localparam int TMR0_B_SYNC_HOLD = 7;
  localparam int TMR0_B_ASYNC_PSR = 1;
  localparam int TMR0_B_SHARED_PSR = 0;
  localparam int TMR0_B_CMP_B = 2;
  localparam int TMR0_B_CMP_A = 1;
  localparam int TMR0_B_OVF = 0;

  // Reset values and counter landmarks
  localparam logic [7:0] TMR0_RST_VAL = 8'h00;
  localparam logic [7:0] TMR0_MAX = 8'hff;
  localparam logic [7:0] TMR0_BOTTOM = 8'h00;

  // Prescaler taps
  localparam int TMR0_PRESC_W = 10;
  localparam int TMR0_TAP_8 = 2;
  localparam int TMR0_TAP_64 = 5;
  localparam int TMR0_TAP_256 = 7;
  localparam int TMR0_TAP_1024 = 9;

  // Clock select codes
  typedef enum logic [2:0] {
    TMR0_CS_STOP = 3'h0,
    TMR0_CS_DIV1 = 3'h1,
    TMR0_CS_DIV8 = 3'h2,
    TMR0_CS_DIV64 = 3'h3,
    TMR0_CS_DIV256 = 3'h4,
    TMR0_CS_DIV1024 = 3'h5,
    TMR0_CS_EXT_FALL = 3'h6,
    TMR0_CS_EXT_RISE = 3'h7
  } tmr0_cs_t;

  // Waveform family seen by the output units
  typedef enum logic [1:0] {
    TMR0_WK_NONPWM,
    TMR0_WK_FAST,
    TMR0_WK_PHASE
  } tmr0_wkind_t;

  // One CPU access on the 8-bit I/O bus
  typedef struct packed {
    logic [7:0] addr;
    logic io_sel;
    logic we;
    logic re;
    logic [7:0] wdata;
  } tmr0_bus_req_t;

endpackage

//--- rtl/tmr0_prescaler.sv
module tmr0_prescaler
  import tmr0_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic presc_clr_i,
  input wire logic [2:0] sel_i,
  input wire logic ext_pin_i,
  output logic tick_o
);

  // Shared divider chain, held at zero while cleared
  logic [TMR0_PRESC_W-1:0] div_q;
  // Two-stage synchroniser plus one history stage for edges
  logic pin_s1_q;
  logic pin_s2_q;
  logic pin_s3_q;
  // Tap terminal counts, one per division
  wire tap8 = &div_q[TMR0_TAP_8:0];
  wire tap64 = &div_q[TMR0_TAP_64:0];
  wire tap256 = &div_q[TMR0_TAP_256:0];
  wire tap1024 = &div_q[TMR0_TAP_1024:0];
  // Edges only look at synchronised stages
  wire pin_rise = pin_s2_q & ~pin_s3_q;
  wire pin_fall = ~pin_s2_q & pin_s3_q;
  tmr0_cs_t sel;

  assign sel = tmr0_cs_t'(sel_i);

  // Divider runs freely unless the prescaler reset is held
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || presc_clr_i)
      div_q <= '0;
    else
      div_q <= div_q + 1'b1;
  end

  // Pin edges count even when the pin is driven by this chip
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
    end
    else
    begin
      pin_s1_q <= ext_pin_i;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // Clock select multiplexer; a held prescaler reset halts the internal clock selections, not the pin edges
  always_comb
  begin
    unique case (sel)
      TMR0_CS_STOP: tick_o = 1'b0;
      TMR0_CS_DIV1: tick_o = ~presc_clr_i;
      TMR0_CS_DIV8: tick_o = tap8 & ~presc_clr_i;
      TMR0_CS_DIV64: tick_o = tap64 & ~presc_clr_i;
      TMR0_CS_DIV256: tick_o = tap256 & ~presc_clr_i;
      TMR0_CS_DIV1024: tick_o = tap1024 & ~presc_clr_i;
      TMR0_CS_EXT_FALL: tick_o = pin_fall;
      TMR0_CS_EXT_RISE: tick_o = pin_rise;
    endcase
  end

endmodule

//--- rtl/tmr0_wave_unit.sv
module tmr0_wave_unit
  import tmr0_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input tmr0_wkind_t kind_i,
  input wire logic [1:0] out_mode_i,
  input wire logic toggle_ok_i,
  input wire logic match_i,
  input wire logic force_i,
  input wire logic bottom_i,
  input wire logic count_up_i,
  output logic wave_o
);

  // Output latch of the waveform generator
  logic wave_q;
  logic wave_d;
  // Action asked for by a match in the current mode
  logic on_match;

  assign wave_o = wave_q;
  assign on_match = match_i | force_i;

  // Next output level by family and output mode
  always_comb
  begin
    wave_d = wave_q;
    unique case (kind_i)
      TMR0_WK_NONPWM:
      begin
        // Forced and real matches act alike here
        if (on_match)
        begin
          unique case (out_mode_i)
            2'h0: wave_d = wave_q;
            2'h1: wave_d = ~wave_q;
            2'h2: wave_d = 1'b0;
            2'h3: wave_d = 1'b1;
          endcase
        end
      end
      TMR0_WK_FAST:
      begin
        // Bottom sets up the period, match ends it
        if (out_mode_i[1] && match_i)
          wave_d = out_mode_i[0];
        else if (out_mode_i[1] && bottom_i)
          wave_d = ~out_mode_i[0];
        else if (out_mode_i == 2'h1 && toggle_ok_i && match_i)
          wave_d = ~wave_q;
      end
      default:
      begin
        // Direction flips the sense in phase correct mode
        if (out_mode_i[1] && match_i)
          wave_d = count_up_i ? out_mode_i[0] : ~out_mode_i[0];
        else if (out_mode_i == 2'h1 && toggle_ok_i && match_i)
          wave_d = ~wave_q;
      end
    endcase
  end

  // Output register
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      wave_q <= 1'b0;
    else
      wave_q <= wave_d;
  end

endmodule

//--- verification/tmr0_cpu_model.sv
// Behavioural CPU core: the only master on the 8-bit I/O bus
module tmr0_cpu_model
  import tmr0_pkg::*;
(
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output tmr0_bus_req_t req_o,
  output logic [2:0] ack_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Low waveform bits last written, so PWM is known
  logic [1:0] wgm_low = 2'b00;

  // Bus idle, no vector executing
  initial
  begin
    req_o = '0;
    ack_o = 3'h0;
  end

  // Write: launched off a falling edge, held across the rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic io);
    logic [7:0] v;
    v = d;
    if (!io && a == TMR0_OFF_CTRL_A)
      wgm_low = d[1:0];
    // Software never strobes a force bit in a PWM mode
    if (!io && a == TMR0_OFF_CTRL_B && wgm_low[0])
      v[7:6] = 2'b00;
    @(negedge clk_i);
    req_o = '{addr: a, io_sel: io, we: 1'b1, re: 1'b0, wdata: v};
    @(negedge clk_i);
    req_o = '0;
  endtask

  // Read: data taken at the rising edge, released after it
  task automatic rd(input logic [7:0] a, input logic io,
                    output logic [7:0] d);
    @(negedge clk_i);
    req_o = '{addr: a, io_sel: io, we: 1'b0, re: 1'b1, wdata: 8'h00};
    @(posedge clk_i);
    d = rdata_i;
    @(negedge clk_i);
    req_o = '0;
  endtask

  // One-cycle pulse as a vector executes
  task automatic ack(input logic [2:0] m);
    @(negedge clk_i);
    ack_o = m;
    @(negedge clk_i);
    ack_o = 3'h0;
  endtask
endmodule

//--- verification/tmr0_core_properties.sv
// Port-level checks on the timer register block
module tmr0_core_properties
  import tmr0_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input tmr0_bus_req_t BUS_REQ_I,
  input wire logic [7:0] BUS_RDATA_O,
  input wire logic GLOBAL_IRQ_EN_I,
  input wire logic ASYNC_MODE_I,
  input wire logic ASYNC_RST_DONE_I,
  input wire logic ASYNC_PRESC_RST_O,
  input wire logic SHARED_PRESC_RST_O,
  input wire logic IRQ_OVF_O,
  input wire logic IRQ_CMP_A_O,
  input wire logic IRQ_CMP_B_O
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  // Sync register hit by either address form
  wire logic sync_hit = BUS_REQ_I.io_sel ?
    (BUS_REQ_I.addr == TMR0_OFF_SYNC - TMR0_IO_SHIFT) :
    (BUS_REQ_I.addr == TMR0_OFF_SYNC);
  wire logic sync_wr = BUS_REQ_I.we && sync_hit;
  wire logic [7:0] wd = BUS_REQ_I.wdata;
  // Data-space read
  wire logic rd_data = BUS_REQ_I.re && !BUS_REQ_I.io_sel;
  // Global bit low now; s_gie_off also needs it low one cycle ago, covering a registered gate
  logic gie_low;
  assign gie_low = !GLOBAL_IRQ_EN_I;

  // A bit that is high for exactly one cycle
  sequence s_one_high(logic s);
    s ##1 !s;
  endsequence
  sequence s_gie_off;
    gie_low && !$past(GLOBAL_IRQ_EN_I);
  endsequence

  a_gie_gates_ovf: assert property (s_gie_off |-> !IRQ_OVF_O)
    else $error("overflow request with global enable low");
  a_gie_gates_a: assert property (s_gie_off |-> !IRQ_CMP_A_O)
    else $error("compare A request with global enable low");
  a_gie_gates_b: assert property (s_gie_off |-> !IRQ_CMP_B_O)
    else $error("compare B request with global enable low");
  a_force_read_zero: assert property (rd_data &&
    BUS_REQ_I.addr == TMR0_OFF_CTRL_B |-> BUS_RDATA_O[7:6] == 2'b00)
    else $error("force bits read nonzero");
  a_mask_unused_zero: assert property (rd_data &&
    BUS_REQ_I.addr == TMR0_OFF_MASK |-> BUS_RDATA_O[7:3] == 5'h00)
    else $error("unused mask bits read nonzero");
  a_io_range_empty: assert property (BUS_REQ_I.re &&
    BUS_REQ_I.io_sel && BUS_REQ_I.addr > TMR0_IO_LAST |->
    BUS_RDATA_O == 8'h00)
    else $error("read beyond I/O range not zero");
  a_shared_rst_pulse: assert property (sync_wr && wd[0] && !wd[7]
    |=> s_one_high(SHARED_PRESC_RST_O))
    else $error("shared prescaler reset not one cycle");
  a_async_self_clear: assert property (sync_wr && wd[1] && !wd[7] &&
    !ASYNC_MODE_I |=> s_one_high(ASYNC_PRESC_RST_O))
    else $error("async prescaler reset not one cycle");
  a_async_waits_done: assert property (sync_wr && wd[1] &&
    ASYNC_MODE_I && !ASYNC_RST_DONE_I ##1 !ASYNC_RST_DONE_I
    |-> ASYNC_PRESC_RST_O)
    else $error("async reset bit dropped before done");
  a_hold_keeps_rst: assert property (sync_wr && wd == 8'h81
    |=> SHARED_PRESC_RST_O [*4])
    else $error("shared reset not held in sync mode");
  a_release_clears: assert property (sync_wr && wd[7] == 1'b0 &&
    wd[1:0] == 2'b00 && !ASYNC_MODE_I
    |=> !SHARED_PRESC_RST_O && !ASYNC_PRESC_RST_O)
    else $error("reset bits not cleared on release");
endmodule

bind tmr0_core tmr0_core_properties u_tmr0_core_properties (
  .CLK_I(CLK_I),
  .RST_N_I(RST_N_I),
  .BUS_REQ_I(BUS_REQ_I),
  .BUS_RDATA_O(BUS_RDATA_O),
  .GLOBAL_IRQ_EN_I(GLOBAL_IRQ_EN_I),
  .ASYNC_MODE_I(ASYNC_MODE_I),
  .ASYNC_RST_DONE_I(ASYNC_RST_DONE_I),
  .ASYNC_PRESC_RST_O(ASYNC_PRESC_RST_O),
  .SHARED_PRESC_RST_O(SHARED_PRESC_RST_O),
  .IRQ_OVF_O(IRQ_OVF_O),
  .IRQ_CMP_A_O(IRQ_CMP_A_O),
  .IRQ_CMP_B_O(IRQ_CMP_B_O)
);

//--- verification/testbench.sv
module testbench
  import tmr0_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic gie = 1'b0;
  logic pin = 1'b0;
  logic amode = 1'b0;
  logic adone = 1'b0;
  tmr0_bus_req_t req;
  logic [2:0] ack;
  logic [7:0] rdata;
  logic arst, srst, iovf, ia, ib, wa, wa_en, wb, wb_en;
  int bad_count = 0;
  int checks = 0;

  // 200 MHz
  always #2.5 clk = ~clk;

  tmr0_cpu_model u_tmr0_cpu_model (.clk_i(clk), .rdata_i(rdata),
    .req_o(req), .ack_o(ack));

  tmr0_core u_tmr0_core (.CLK_I(clk), .RST_N_I(rst_n), .BUS_REQ_I(req),
    .BUS_RDATA_O(rdata), .GLOBAL_IRQ_EN_I(gie), .IRQ_ACK_I(ack),
    .EXT_COUNT_PIN_I(pin), .ASYNC_MODE_I(amode),
    .ASYNC_RST_DONE_I(adone), .ASYNC_PRESC_RST_O(arst),
    .SHARED_PRESC_RST_O(srst), .IRQ_OVF_O(iovf), .IRQ_CMP_A_O(ia),
    .IRQ_CMP_B_O(ib), .WAVE_OUT_A_O(wa), .WAVE_OUT_A_EN_O(wa_en),
    .WAVE_OUT_B_O(wb), .WAVE_OUT_B_EN_O(wb_en));

  // Compare and count; mismatches print one line
  task automatic check(input string n, input logic [7:0] seen,
                       input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic rchk(input string n, input logic [7:0] a,
                      input logic [7:0] e);
    logic [7:0] v;
    u_tmr0_cpu_model.rd(a, 1'b0, v);
    check(n, v, e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_tmr0_cpu_model.wr(a, d, 1'b0);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Reset values, access kinds, both address forms, unmapped places
  task automatic t_regs();
    logic [7:0] offs [6] = '{TMR0_OFF_SYNC, TMR0_OFF_CTRL_B,
      TMR0_OFF_COUNT, TMR0_OFF_CMP_A, TMR0_OFF_CMP_B, TMR0_OFF_MASK};
    logic [7:0] v;
    foreach (offs[i])
      rchk("reset value", offs[i], 8'h00);
    wr(TMR0_OFF_COUNT, 8'ha5);
    rchk("count", TMR0_OFF_COUNT, 8'ha5);
    u_tmr0_cpu_model.wr(TMR0_OFF_CMP_A - TMR0_IO_SHIFT, 8'h3c, 1'b1);
    rchk("cmp a via io", TMR0_OFF_CMP_A, 8'h3c);
    wr(TMR0_OFF_CMP_B, 8'hc3);
    rchk("cmp b", TMR0_OFF_CMP_B, 8'hc3);
    wr(TMR0_OFF_MASK, 8'hff);
    rchk("mask", TMR0_OFF_MASK, 8'h07);
    wr(TMR0_OFF_MASK, 8'h00);
    wr(TMR0_OFF_CTRL_B, 8'hc8);
    rchk("ctrl b", TMR0_OFF_CTRL_B, 8'h08);
    wr(TMR0_OFF_CTRL_B, 8'h00);
    u_tmr0_cpu_model.rd(8'h47, 1'b1, v);
    check("io beyond range", v, 8'h00);
    rchk("unmapped", 8'h49, 8'h00);
  endtask

  // Forced compares in CTC mode drive outputs only
  task automatic t_force();
    wr(TMR0_OFF_CTRL_A, 8'h72);
    cyc(1);
    check("pin enables", {6'h0, wb_en, wa_en}, 8'h03);
    wr(TMR0_OFF_CTRL_B, 8'hc0);
    cyc(1);
    check("force both", {6'h0, wb, wa}, 8'h03);
    wr(TMR0_OFF_CTRL_B, 8'h80);
    cyc(1);
    check("force toggle", {6'h0, wb, wa}, 8'h02);
    wr(TMR0_OFF_CTRL_A, 8'ha2);
    wr(TMR0_OFF_CTRL_B, 8'hc0);
    cyc(1);
    check("force clear", {6'h0, wb, wa}, 8'h00);
    rchk("no flag", TMR0_OFF_FLAGS, 8'h00);
    rchk("no clear", TMR0_OFF_COUNT, 8'ha5);
    // Fast PWM, non-inverting: output set as the count wraps to bottom
    wr(TMR0_OFF_CTRL_A, 8'h83);
    wr(TMR0_OFF_COUNT, 8'hfe);
    wr(TMR0_OFF_CTRL_B, 8'h01);
    cyc(4);
    check("pwm set at bottom", {7'h0, wa}, 8'h01);
    wr(TMR0_OFF_CTRL_B, 8'h00);
    wr(TMR0_OFF_CTRL_A, 8'h00);
    cyc(1);
    check("disconnect", {6'h0, wb_en, wa_en}, 8'h00);
  endtask

  // Three requests: raised, gated, acknowledged, cleared, masked
  task automatic t_irq();
    wr(TMR0_OFF_MASK, 8'h07);
    gie = 1'b1;
    wr(TMR0_OFF_CMP_A, 8'h04);
    wr(TMR0_OFF_CMP_B, 8'h06);
    wr(TMR0_OFF_COUNT, 8'hfc);
    wr(TMR0_OFF_CTRL_B, 8'h01);
    cyc(16);
    wr(TMR0_OFF_CTRL_B, 8'h00);
    cyc(2);
    check("requests", {5'h0, ib, ia, iovf}, 8'h07);
    rchk("flags", TMR0_OFF_FLAGS, 8'h07);
    gie = 1'b0;
    cyc(2);
    check("gated", {5'h0, ib, ia, iovf}, 8'h00);
    gie = 1'b1;
    u_tmr0_cpu_model.ack(3'h1);
    cyc(1);
    check("vector clear", {5'h0, ib, ia, iovf}, 8'h06);
    wr(TMR0_OFF_FLAGS, 8'h02);
    cyc(1);
    check("write one", {5'h0, ib, ia, iovf}, 8'h04);
    wr(TMR0_OFF_MASK, 8'h03);
    cyc(1);
    check("masked", {5'h0, ib, ia, iovf}, 8'h00);
    wr(TMR0_OFF_FLAGS, 8'h07);
    wr(TMR0_OFF_MASK, 8'h00);
    gie = 1'b0;
  endtask

  // A counter write hides the match on the next tick only
  task automatic t_suppress();
    wr(TMR0_OFF_CMP_A, 8'h30);
    wr(TMR0_OFF_COUNT, 8'h30);
    wr(TMR0_OFF_CTRL_B, 8'h01);
    cyc(4);
    wr(TMR0_OFF_CTRL_B, 8'h00);
    rchk("blocked", TMR0_OFF_FLAGS, 8'h00);
    wr(TMR0_OFF_COUNT, 8'h2e);
    wr(TMR0_OFF_CTRL_B, 8'h01);
    cyc(4);
    wr(TMR0_OFF_CTRL_B, 8'h00);
    rchk("match", TMR0_OFF_FLAGS, 8'h02);
    wr(TMR0_OFF_FLAGS, 8'h07);
  endtask

  // Every clock source; prescaler held in sync mode, then released, before each internal one
  task automatic t_clock();
    int divs [6] = '{1, 1, 8, 64, 256, 1024};
    logic [7:0] v;
    logic ok;
    for (int cs = 0; cs < 6; cs++)
    begin
      wr(TMR0_OFF_SYNC, 8'h81);
      wr(TMR0_OFF_COUNT, 8'h00);
      wr(TMR0_OFF_CTRL_B, 8'(cs));
      check("held", {7'h0, srst}, 8'h01);
      rchk("held bits", TMR0_OFF_SYNC, 8'h81);
      wr(TMR0_OFF_SYNC, 8'h00);
      check("released", {7'h0, srst}, 8'h00);
      cyc(32 * divs[cs]);
      wr(TMR0_OFF_CTRL_B, 8'h00);
      u_tmr0_cpu_model.rd(TMR0_OFF_COUNT, 1'b0, v);
      // Stop and release writes add a cycle or two of slack
      ok = (cs == 0) ? (v == 8'h00) : (v >= 8'd31 && v <= 8'd35);
      check("rate", {7'h0, ok}, 8'h01);
    end
    for (int cs = 6; cs < 8; cs++)
    begin
      wr(TMR0_OFF_COUNT, 8'h00);
      wr(TMR0_OFF_CTRL_B, 8'(cs));
      repeat (3)
      begin
        pin = 1'b1;
        cyc(4);
        pin = 1'b0;
        cyc(4);
      end
      wr(TMR0_OFF_CTRL_B, 8'h00);
      rchk("pin edges", TMR0_OFF_COUNT, 8'h03);
    end
  endtask

  // Async reset bit waits for done; both bits self-clear otherwise
  task automatic t_sync();
    amode = 1'b1;
    wr(TMR0_OFF_SYNC, 8'h02);
    cyc(3);
    check("async held", {7'h0, arst}, 8'h01);
    adone = 1'b1;
    cyc(3);
    check("async done", {7'h0, arst}, 8'h00);
    amode = 1'b0;
    adone = 1'b0;
    wr(TMR0_OFF_SYNC, 8'h03);
    cyc(2);
    rchk("self clear", TMR0_OFF_SYNC, 8'h00);
  endtask

  task automatic tally_and_finish();
    if (bad_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Main sequence after 16 cycles of reset
  initial
  begin
    cyc(16);
    rst_n = 1'b1;
    t_regs();
    t_force();
    t_irq();
    t_suppress();
    t_clock();
    t_sync();
    tally_and_finish();
  end

  // Run needs about 45000 cycles; cut a hang at 60000
  initial
  begin
    #300000;
    bad_count++;
    tally_and_finish();
  end
endmodule
